// ==== rtl/lcci_device.sv ====
// memory end: samples control on the link clock, decodes commands,
// tracks open banks and power states, stores masked double-rate writes
// assumes the link clock comes from the controller end; small array only

`default_nettype none

// Functional notes
// - sample control on rising clock crossing
// - data on both clock crossings
// - clock gate high runs clocks, drivers
// - gate low enters power-down or self refresh
// - gate synchronous, except self refresh exit
// - power-down ignores all but clock gate
// - select low enables command decoder
// - select high masks the command
// - select is command bit, picks rank
// - three strobes with select form command
// - masked byte leaves location unchanged
// - mask sampled on both strobe edges
// - single die uses first gate only
// - second select only on stacks
// - bank address selects bank, mode register
// - bit 10 high precharges every bank
// - read strobe edge aligned, write centred
module lcci_device import lcci_pkg::*; #(
  parameter bit RANK_B = 1'b0
) (
  input wire logic rstn, // async reset, low
  lcci_if.device link, // link pins
  output lcci_pwr_t state_o, // power state
  output logic [BANKS-1:0] bank_open_o, // bank has a row open
  output logic [BANKS-1:0][ADDR_W-1:0] mode_o, // mode registers
  output logic [2:0] last_cmd_o, // last decoded command
  output logic clocks_run_o, // internal clocks running
  output logic self_ref_o // in self refresh
);

  logic ck;
  logic cke;
  logic sel_n;
  logic [2:0] cmd;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic take;

  lcci_pwr_t state_q;
  logic [BANKS-1:0] bank_open_q;
  logic [BANKS-1:0][ADDR_W-1:0] mode_q;
  logic [2:0] last_cmd_q;

  logic rd_act_q;
  logic [DQ_W-1:0] rd_p_q;
  logic [DQ_W-1:0] rd_hold_q;
  logic [DQ_W-1:0] rd_n_q;

  logic wr_pend_q;
  logic [BA_W-1:0] wr_ba_q;
  logic [COL_W-1:0] wr_col_q;
  logic [CAP_W-1:0] cap0_q;
  logic [CAP_W-1:0] cap1_q;

  logic [DQ_W-1:0] mem [MEM_WORDS];

  // word index of one beat in the array
  function automatic logic [MEM_IDX_W-1:0] idx(
    input logic [BA_W-1:0] b,
    input logic [COL_W-1:0] c,
    input logic beat
  );
    return {b, c, beat};
  endfunction

  function automatic logic [DQ_W-1:0] merge(
    input logic [DQ_W-1:0] old,
    input logic [CAP_W-1:0] cap
  );
    logic [DQ_W-1:0] res;
    res[7:0] = cap[DQ_W] ? old[7:0] : cap[7:0];
    res[15:8] = cap[DQ_W+1] ? old[15:8] : cap[15:8];
    return res;
  endfunction

  // true clock rising is the crossing
  assign ck = link.ck;

  // this die listens to one gate
  assign cke = RANK_B ? link.rank_b_clock_gate : link.rank_a_clock_gate;

  // second select only on stacked die
  assign sel_n = RANK_B ? link.rank_b_select_n : link.rank_a_select_n;

  assign cmd = {link.ras_n, link.cas_n, link.we_n};
  assign ba = link.ba;
  assign addr = link.addr;

  assign take = (state_q == PWR_RUN) & cke & ~sel_n;

  // power state, stepped on the link clock
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) begin
      state_q <= PWR_RUN;
    end else begin
      case (state_q)
        PWR_RUN: begin
          if (!cke) begin
            if (!sel_n && cmd == CMD_REF) begin
              state_q <= PWR_SELF_REF;
            end else if (|bank_open_q) begin
              state_q <= PWR_PD_ACT;
            end else begin
              state_q <= PWR_PD_PRE;
            end
          end
        end
        PWR_PD_PRE, PWR_PD_ACT: begin
          if (cke) begin
            state_q <= PWR_RUN;
          end
        end
        PWR_SELF_REF: begin
          if (cke) begin
            state_q <= PWR_RUN;
          end
        end
        default: begin
          state_q <= PWR_RUN;
        end
      endcase
    end
  end

  // self refresh exit seen without a clock edge
  // the link clock may be stopped here, so the flag drops at once
  assign self_ref_o = (state_q == PWR_SELF_REF) & ~cke;

  // clocks run only with gate high
  assign clocks_run_o = cke & (state_q == PWR_RUN);

  // bank tracking and command capture
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) begin
      bank_open_q <= '0;
      last_cmd_q <= CMD_NOP;
      rd_act_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_ba_q <= '0;
      wr_col_q <= '0;
    end else begin
      rd_act_q <= 1'b0;
      wr_pend_q <= 1'b0;
      if (take) begin
        last_cmd_q <= cmd;
        case (cmd)
          CMD_ACT: begin
            bank_open_q[ba] <= 1'b1;
          end
          CMD_PRE: begin
            if (addr[PRE_ALL_BIT]) begin
              bank_open_q <= '0;
            end else begin
              bank_open_q[ba] <= 1'b0;
            end
          end
          CMD_RD: begin
            // reads to a closed bank are dropped
            rd_act_q <= bank_open_q[ba];
          end
          CMD_WR: begin
            wr_pend_q <= bank_open_q[ba];
            wr_ba_q <= ba;
            wr_col_q <= addr[COL_W:1];
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) begin
      mode_q <= '0;
    end else if (take && cmd == CMD_LMR) begin
      mode_q[ba] <= addr;
    end
  end

  // mask and data on strobe rise
  // strobe edges are a source-synchronous clock; the result is read
  // three quarters of a period later on the next link clock rise
  always_ff @(posedge link.dqs) begin
    cap0_q <= {link.upper_byte_write_mask, link.lower_byte_write_mask, link.dq};
  end

  // mask and data on strobe fall
  always_ff @(negedge link.dqs) begin
    cap1_q <= {link.upper_byte_write_mask, link.lower_byte_write_mask, link.dq};
  end

  // array write one clock after the write command
  always_ff @(posedge ck) begin
    if (wr_pend_q) begin
      mem[idx(wr_ba_q, wr_col_q, 1'b0)] <= merge(mem[idx(wr_ba_q, wr_col_q, 1'b0)], cap0_q);
      mem[idx(wr_ba_q, wr_col_q, 1'b1)] <= merge(mem[idx(wr_ba_q, wr_col_q, 1'b1)], cap1_q);
    end
  end

  // read beats fetched at the command edge
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) begin
      rd_p_q <= '0;
      rd_hold_q <= '0;
    end else if (take && cmd == CMD_RD) begin
      // a write to the same burst lands at this very edge, so pass it on
      if (wr_pend_q && wr_ba_q == ba && wr_col_q == addr[COL_W:1]) begin
        rd_p_q <= merge(mem[idx(ba, addr[COL_W:1], 1'b0)], cap0_q);
        rd_hold_q <= merge(mem[idx(ba, addr[COL_W:1], 1'b1)], cap1_q);
      end else begin
        rd_p_q <= mem[idx(ba, addr[COL_W:1], 1'b0)];
        rd_hold_q <= mem[idx(ba, addr[COL_W:1], 1'b1)];
      end
    end
  end

  always_ff @(negedge ck or negedge rstn) begin
    if (!rstn) begin
      rd_n_q <= '0;
    end else begin
      rd_n_q <= rd_hold_q;
    end
  end

  assign link.dev_dq_o = ck ? rd_p_q : rd_n_q;

  assign link.dev_dqs_o = rd_act_q & ck;

  assign link.dev_dq_oe = rd_act_q & cke;
  assign link.dev_dqs_oe = rd_act_q & cke;

  // status toward the user side
  assign state_o = state_q;
  assign bank_open_o = bank_open_q;
  assign mode_o = mode_q;
  assign last_cmd_o = last_cmd_q;

endmodule

`default_nettype wire

// ==== rtl/lcci_pkg.sv ====
// constants, command codes and types shared by the lpddr link ends
// assumes both ends and the bench import it whole
`default_nettype none
package lcci_pkg;
  localparam int ADDR_W = 14;
  localparam int BA_W = 2;
  localparam int DQ_W = 16;
  localparam int DM_W = 2;
  localparam int BANKS = 4;
  localparam int COL_W = 2;
  localparam int MEM_IDX_W = BA_W + COL_W + 1;
  localparam int MEM_WORDS = 1 << MEM_IDX_W;
  localparam int FIFO_DEPTH = 4;
  localparam int CAP_W = DQ_W + DM_W;
  // address bit that widens a precharge to every bank
  localparam int PRE_ALL_BIT = 10;
  // {row strobe, column strobe, write enable}, all active low
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // link clock made from ref_clk by a divider
  localparam int REF_CLK_NS = 50;
  localparam int CK_PERIOD_NS = 200;
  localparam int CK_DIV = CK_PERIOD_NS / REF_CLK_NS;
  localparam int PH_W = $clog2(CK_DIV);
  // ref_clk phases within one link clock period; ck is high in 0 and 1
  localparam logic [PH_W-1:0] PH_RESET = 2'h0;
  localparam logic [PH_W-1:0] PH_CMD = 2'h1;
  localparam logic [PH_W-1:0] PH_CAP_LO = 2'h2;
  localparam logic [PH_W-1:0] PH_DATA = 2'h3;
  localparam logic [PH_W-1:0] PH_CAP_HI = 2'h0;
  localparam logic [DQ_W-1:0] DQ_RESET = 16'h0000;

  typedef enum logic [1:0] {PWR_RUN, PWR_PD_PRE, PWR_PD_ACT, PWR_SELF_REF} lcci_pwr_t;

  typedef struct packed {
    logic [2:0] cmd;
    logic rank;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [2*DQ_W-1:0] wdata;
    logic [2*DM_W-1:0] wmask;
  } lcci_req_t;
endpackage
`default_nettype wire

// ==== rtl/lcci_if.sv ====
// link pins between controller end and memory end
// assumes the bench instantiates it once; two-way pins resolved here
`default_nettype none
interface lcci_if;
  import lcci_pkg::*;
  logic ck;
  logic ck_n;
  logic rank_a_clock_gate;
  logic rank_b_clock_gate;
  logic rank_a_select_n;
  logic rank_b_select_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic upper_byte_write_mask;
  logic lower_byte_write_mask;
  logic [DQ_W-1:0] host_dq_o;
  logic host_dq_oe;
  logic host_dqs_o;
  logic host_dqs_oe;
  logic [DQ_W-1:0] dev_dq_o;
  logic dev_dq_oe;
  logic dev_dqs_o;
  logic dev_dqs_oe;
  logic [DQ_W-1:0] dq;
  logic dqs;

  // wire level from the enables; an undriven bus reads low
  assign dq = host_dq_oe ? host_dq_o : (dev_dq_oe ? dev_dq_o : DQ_RESET);
  assign dqs = host_dqs_oe ? host_dqs_o : (dev_dqs_oe & dev_dqs_o);

  modport host (
    output ck, ck_n, rank_a_clock_gate, rank_b_clock_gate, rank_a_select_n, rank_b_select_n,
    output ras_n, cas_n, we_n, ba, addr, upper_byte_write_mask, lower_byte_write_mask,
    output host_dq_o, host_dq_oe, host_dqs_o, host_dqs_oe,
    input dq
  );
  modport device (
    input ck, rank_a_clock_gate, rank_b_clock_gate, rank_a_select_n, rank_b_select_n,
    input ras_n, cas_n, we_n, ba, addr, upper_byte_write_mask, lower_byte_write_mask,
    input dq, dqs,
    output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_oe
  );
endinterface
`default_nettype wire

// ==== rtl/lcci_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
// assumes one clock; D need not be a power of two
`default_nettype none
module lcci_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk, // fifo clock
  input wire logic rstn, // async reset, low
  input wire logic in_valid, // writer has a word
  output logic in_ready, // room for a word
  input wire logic [W-1:0] in_data, // word in
  output logic out_valid, // a word waits
  input wire logic out_ready, // reader takes it
  output logic [W-1:0] out_data // oldest word
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = D[AW:0];
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic push, pop;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  // full and empty straight from the count
  assign in_ready = cnt_q != FULL;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= nxt(wp_q);
      end
      if (pop) begin
        rp_q <= nxt(rp_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/lcci_host.sv ====
// controller end: queues requests, makes the link clock, drives pins
// assumes ref_clk at 20 MHz; link clock is ref_clk divided by four
`default_nettype none
module lcci_host import lcci_pkg::*; #(
  parameter bit DUAL_DIE = 1'b0
) (
  input wire logic ref_clk, // system clock
  input wire logic rstn, // async reset, low
  input wire logic req_valid, // request offered
  output logic req_ready, // queue has room
  input wire lcci_req_t req, // command, rank, address, data
  input wire logic gate_a, // wanted level of rank a clock gate
  input wire logic gate_b, // wanted level of rank b clock gate
  output logic rd_valid, // read burst returned, pulse
  output logic [2*DQ_W-1:0] rd_data, // beat 1 high, beat 0 low
  lcci_if.host link // link pins
);
  logic [PH_W-1:0] ph_q;
  lcci_req_t head;
  logic head_valid, pop, gate_ok, drop, issue;
  logic wr_arm_q, wr_act_q;
  logic [2*CAP_W-1:0] wbuf_q, wact_q;
  logic [1:0] rd_stage_q;
  logic [DQ_W-1:0] s1_q, s2_q, lo_q;
  logic [2*DQ_W-1:0] rd_data_q;
  logic rd_valid_q;
  logic cs_a_q, cs_b_q, gate_a_q, gate_b_q;
  logic [2:0] cmd_q;
  logic [BA_W-1:0] ba_q;
  logic [ADDR_W-1:0] addr_q;

  // the drain stalls in power-down, so the queue really fills
  lcci_fifo #(.W($bits(lcci_req_t)), .D(FIFO_DEPTH)) u_queue (
    .clk(ref_clk),
    .rstn(rstn),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req),
    .out_valid(head_valid),
    .out_ready(pop),
    .out_data(head)
  );

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ph_q <= PH_RESET;
    end else begin
      ph_q <= ph_q + 1'b1;
    end
  end
  assign link.ck = ~ph_q[1];
  assign link.ck_n = ph_q[1];

  // rank b dropped on single die
  assign drop = head.rank & ~DUAL_DIE;
  // refresh may pass with gate low
  assign gate_ok = (head.rank ? gate_b : gate_a) | (head.cmd == CMD_REF);
  assign pop = head_valid & (ph_q == PH_CMD) & (gate_ok | drop);
  assign issue = pop & ~drop;

  // command pins change at ck fall
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cs_a_q <= 1'b1;
      cs_b_q <= 1'b1;
      cmd_q <= CMD_NOP;
      ba_q <= '0;
      addr_q <= '0;
      gate_a_q <= 1'b0;
      gate_b_q <= 1'b0;
    end else if (ph_q == PH_CMD) begin
      cs_a_q <= ~(issue & ~head.rank);
      cs_b_q <= ~(issue & head.rank);
      cmd_q <= issue ? head.cmd : CMD_NOP;
      ba_q <= head.ba;
      addr_q <= head.addr;
      gate_a_q <= gate_a;
      gate_b_q <= gate_b & DUAL_DIE;
    end
  end
  assign link.rank_a_select_n = cs_a_q;
  assign link.rank_b_select_n = cs_b_q;
  assign link.rank_a_clock_gate = gate_a_q;
  assign link.rank_b_clock_gate = gate_b_q;
  assign {link.ras_n, link.cas_n, link.we_n} = cmd_q;
  assign link.ba = ba_q;
  assign link.addr = addr_q;

  // write data staged twice so back-to-back writes do not collide
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_arm_q <= 1'b0;
      wr_act_q <= 1'b0;
      wbuf_q <= '0;
      wact_q <= '0;
    end else begin
      if (ph_q == PH_CMD) begin
        wr_arm_q <= issue & (head.cmd == CMD_WR);
        wbuf_q <= {head.wmask[3:2], head.wdata[31:16], head.wmask[1:0], head.wdata[15:0]};
      end
      if (ph_q == PH_DATA) begin
        wr_act_q <= wr_arm_q;
        wact_q <= wbuf_q;
      end
    end
  end

  assign link.host_dqs_o = wr_act_q & (ph_q[0] ^ ph_q[1]);
  assign link.host_dqs_oe = wr_act_q;
  assign link.host_dq_oe = wr_act_q;
  assign link.host_dq_o = ph_q[1] ? wact_q[CAP_W +: DQ_W] : wact_q[0 +: DQ_W];
  assign {link.upper_byte_write_mask, link.lower_byte_write_mask} =
    ph_q[1] ? wact_q[CAP_W+DQ_W +: DM_W] : wact_q[DQ_W +: DM_W];

  // read data crosses from the device clock through two flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= link.dq;
      s2_q <= s1_q;
    end
  end

  // beats picked at fixed phases; the divider makes the timing known
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_stage_q <= '0;
      lo_q <= '0;
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      if (ph_q == PH_CMD) begin
        rd_stage_q <= {rd_stage_q[0], issue & (head.cmd == CMD_RD)};
      end
      if (ph_q == PH_CAP_LO && rd_stage_q[1]) begin
        lo_q <= s2_q;
      end
      if (ph_q == PH_CAP_HI && rd_stage_q[1]) begin
        rd_data_q <= {s2_q, lo_q};
        rd_valid_q <= 1'b1;
      end
    end
  end
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
endmodule
`default_nettype wire

// ==== rtl/lcci_unused_placeholder_never.sv ====
// empty unit, holds no code
// assumes nothing of its surroundings
`default_nettype none
`default_nettype wire

// ==== testbench/lcci_checker.sv ====
// link pin checks between controller end and memory end
// assumes instantiation beside the interface, single-die setup
`default_nettype none
module lcci_checker import lcci_pkg::*; (
  input wire logic ck, // link clock
  input wire logic ck_n, // link clock complement
  input wire logic rstn, // async reset, low
  input wire logic rank_a_clock_gate, // rank a gate pin
  input wire logic rank_a_select_n, // rank a select pin
  input wire logic rank_b_select_n, // rank b select pin
  input wire logic ras_n, // row strobe
  input wire logic cas_n, // column strobe
  input wire logic we_n, // write enable
  input wire logic host_dq_oe, // host drives data
  input wire logic host_dqs_o, // host strobe level
  input wire logic host_dqs_oe, // host drives strobe
  input wire logic dev_dq_oe // device drives data
);
  logic wr_now;
  logic rd_now;

  // command on rank a at this rise; host sends it only with the gate high
  assign wr_now = !rank_a_select_n && {ras_n, cas_n, we_n} == CMD_WR;
  assign rd_now = !rank_a_select_n && {ras_n, cas_n, we_n} == CMD_RD;

  default clocking cb @(posedge ck);
  endclocking
  default disable iff (!rstn);

  chk_ck_pair_cross: assert property (ck_n)
    else $error("complement clock high before rise missing");
  chk_rank_b_idle: assert property (rank_b_select_n)
    else $error("second select driven on single die");
  chk_deselect_quiet: assert property (rank_a_select_n |=> !dev_dq_oe)
    else $error("device drove data after deselected cycle");
  chk_gate_low_quiet: assert property (!rank_a_clock_gate |=> !dev_dq_oe)
    else $error("device drove data with clock gate low");
  chk_write_centre_strobe: assert property (wr_now |=> host_dq_oe && host_dqs_oe && !host_dqs_o)
    else $error("write burst strobe or data drive wrong");
  chk_write_dev_silent: assert property (wr_now |=> !dev_dq_oe)
    else $error("device drove data during write");
  chk_read_host_silent: assert property (rd_now |=> !host_dq_oe)
    else $error("host drove data during read");
  chk_no_bus_fight: assert property (!(host_dq_oe && dev_dq_oe))
    else $error("both ends drive data");
endmodule
`default_nettype wire

// ==== testbench/test_lpddr_clock_command_inputs.sv ====
// bench joining controller end and memory end through the link
// assumes package, interface and both ends compiled before it
`default_nettype none
module test_lpddr_clock_command_inputs import lcci_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready;
  lcci_req_t req = '0;
  logic gate_a = 1'b0;
  logic gate_b = 1'b0;
  logic gate_next = 1'b1;
  logic rd_valid;
  logic [2*DQ_W-1:0] rd_data;
  lcci_pwr_t state;
  logic [BANKS-1:0] bank_open;
  logic [BANKS-1:0][ADDR_W-1:0] mode;
  logic [2:0] last_cmd;
  logic clocks_run;
  logic self_ref;
  int n_fail = 0;
  int num_checks = 0;

  lcci_if bus ();
  lcci_host #(.DUAL_DIE(1'b0)) lcci_host_inst (.ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .gate_a(gate_a), .gate_b(gate_b), .rd_valid(rd_valid),
    .rd_data(rd_data), .link(bus.host));
  lcci_device #(.RANK_B(1'b0)) lcci_device_inst (.rstn(rstn), .link(bus.device), .state_o(state),
    .bank_open_o(bank_open), .mode_o(mode), .last_cmd_o(last_cmd), .clocks_run_o(clocks_run),
    .self_ref_o(self_ref));
  lcci_checker lcci_checker_inst (.ck(bus.ck), .ck_n(bus.ck_n), .rstn(rstn),
    .rank_a_clock_gate(bus.rank_a_clock_gate), .rank_a_select_n(bus.rank_a_select_n),
    .rank_b_select_n(bus.rank_b_select_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n),
    .host_dq_oe(bus.host_dq_oe), .host_dqs_o(bus.host_dqs_o), .host_dqs_oe(bus.host_dqs_oe),
    .dev_dq_oe(bus.dev_dq_oe));

  // reference clock, 50 ns period
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hold the request until the queue takes it; gate follows gate_next
  task automatic send(input logic [2:0] c, input logic r, input logic [BA_W-1:0] b,
      input logic [ADDR_W-1:0] a, input logic [31:0] d = 32'h0000_0000, input logic [3:0] m = 4'h0);
    @(negedge ref_clk);
    req = '{cmd: c, rank: r, ba: b, addr: a, wdata: d, wmask: m};
    req_valid = 1'b1;
    for (int i = 0; i < 64 && req_ready !== 1'b1; i++) @(negedge ref_clk);
    check("queue ready", req_ready, 32'h0000_0001);
    @(posedge ref_clk);
    @(negedge ref_clk);
    req_valid = 1'b0;
    // gate moves only once the request is queued, so a refresh pops with it
    gate_a = gate_next;
  endtask

  // queue drains at one link period per entry plus pin latency
  task automatic settle();
    repeat (24) @(negedge ref_clk);
  endtask

  // read a burst and compare both beats; closed banks read as idle bus
  task automatic read_check(input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    send(CMD_RD, 1'b0, b, a);
    for (int i = 0; i < 40 && rd_valid !== 1'b1; i++) @(negedge ref_clk);
    check("read valid", rd_valid, 32'h0000_0001);
    check("read burst", rd_data, exp);
  endtask

  // a hang far past the fewer than a thousand cycles the tests need ends here
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    gate_a = 1'b1;
    settle();
    check("power state", state, PWR_RUN);
    check("clocks run", clocks_run, 32'h0000_0001);
    check("second gate", bus.rank_b_clock_gate, 32'h0000_0000);
    // masked double-rate writes over one location
    send(CMD_ACT, 1'b0, 2'h1, 14'h0000);
    send(CMD_WR, 1'b0, 2'h1, 14'h0002, 32'hAAAA_5555, 4'h0);
    read_check(2'h1, 14'h0002, 32'hAAAA_5555);
    send(CMD_WR, 1'b0, 2'h1, 14'h0002, 32'h1234_5678, 4'h6);
    read_check(2'h1, 14'h0002, 32'h12AA_5578);
    send(CMD_WR, 1'b0, 2'h1, 14'h0002, 32'hFFFF_FFFF, 4'hF);
    read_check(2'h1, 14'h0002, 32'h12AA_5578);
    send(CMD_WR, 1'b0, 2'h1, 14'h0002, 32'h0F0F_F0F0, 4'h9);
    read_check(2'h1, 14'h0002, 32'h120F_F078);
    $display("test masked writes done");
    // second rank dropped, closed bank gives nothing
    send(CMD_WR, 1'b1, 2'h1, 14'h0002, 32'h0000_0000, 4'h0);
    read_check(2'h1, 14'h0002, 32'h120F_F078);
    read_check(2'h2, 14'h0000, 32'h0000_0000);
    $display("test rank select done");
    // every command code, then every mode register
    for (int c = 0; c < 8; c++) begin
      send(c[2:0], 1'b0, 2'h0, 14'h0000);
      settle();
      check("decoded command", last_cmd, c[2:0]);
    end
    for (int b = 0; b < BANKS; b++) begin
      send(CMD_LMR, 1'b0, b[1:0], 14'h0030 + 14'(b));
      settle();
      check("mode register", mode[b], 14'h0030 + 14'(b));
    end
    $display("test command decode done");
    // bank tracking, power-down and self refresh
    send(CMD_ACT, 1'b0, 2'h3, 14'h0000);
    settle();
    check("open banks", bank_open, 4'hB);
    send(CMD_PRE, 1'b0, 2'h3, 14'h0000);
    settle();
    check("open banks", bank_open, 4'h3);
    @(negedge ref_clk);
    gate_a = 1'b0;
    settle();
    check("power state", state, PWR_PD_ACT);
    check("clocks run", clocks_run, 32'h0000_0000);
    // leave power-down first; the exit edge itself takes no command
    @(negedge ref_clk);
    gate_a = 1'b1;
    settle();
    check("power state", state, PWR_RUN);
    send(CMD_PRE, 1'b0, 2'h2, 14'h0400);
    settle();
    check("power state", state, PWR_RUN);
    check("open banks", bank_open, 4'h0);
    @(negedge ref_clk);
    gate_a = 1'b0;
    settle();
    check("power state", state, PWR_PD_PRE);
    // self refresh is entered from run: gate drops with the refresh
    @(negedge ref_clk);
    gate_a = 1'b1;
    settle();
    gate_next = 1'b0;
    send(CMD_REF, 1'b0, 2'h0, 14'h0000);
    settle();
    check("power state", state, PWR_SELF_REF);
    check("self refresh", self_ref, 32'h0000_0001);
    @(negedge ref_clk);
    gate_a = 1'b1;
    for (int i = 0; i < 16 && bus.rank_a_clock_gate !== 1'b1; i++) @(negedge ref_clk);
    check("self refresh", self_ref, 32'h0000_0000);
    check("power state", state, PWR_SELF_REF);
    settle();
    check("power state", state, PWR_RUN);
    $display("test power states done");
    finish_test();
  end
endmodule
`default_nettype wire
